// ---- inc/lscb_defs.svh ----
// Offsets, field positions, encodings and widths for the status and counter block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef LSCB_DEFS_SVH
`define LSCB_DEFS_SVH
// Status word field positions
`define LSCB_BIT_CMD_DONE 15
`define LSCB_BIT_RX_DONE 14
`define LSCB_BIT_CU_INACT 13
`define LSCB_BIT_RU_HALT 12
`define LSCB_CU_STATE_LO 8
`define LSCB_CU_STATE_HI 10
`define LSCB_RU_STATE_LO 4
`define LSCB_RU_STATE_HI 7
`define LSCB_BIT_THROT 3
// Command word acknowledge bits and unit command fields, relative to upper half of the first long word
`define LSCB_ACK_CMD_DONE 15
`define LSCB_ACK_RX_DONE 14
`define LSCB_ACK_CU_INACT 13
`define LSCB_ACK_RU_HALT 12
`define LSCB_CU_CMD_LO 8
`define LSCB_CU_CMD_HI 10
`define LSCB_RU_CMD_LO 4
`define LSCB_RU_CMD_HI 6
// Start command code
`define LSCB_CMD_START 3'h1
// Byte offsets from the control block base (linear layout)
`define LSCB_OFS_STATUS 32'h0000_0000
`define LSCB_OFS_CMDLIST 32'h0000_0004
`define LSCB_OFS_RXAREA 32'h0000_0008
`define LSCB_OFS_CRC 32'h0000_000C
`define LSCB_OFS_ALN 32'h0000_0010
`define LSCB_OFS_RSC 32'h0000_0014
`define LSCB_OFS_OVR 32'h0000_0018
`define LSCB_OFS_CDT 32'h0000_001C
`define LSCB_OFS_SHRT 32'h0000_0020
// Counter select indices
`define LSCB_CNT_CRC 0
`define LSCB_CNT_ALN 1
`define LSCB_CNT_SHRT 2
`define LSCB_CNT_RSC 3
`define LSCB_CNT_OVR 4
`define LSCB_CNT_CDT 5
`define LSCB_NCNT 6
// Receive collision threshold in bytes
`define LSCB_MIN_CDT_BYTES 16'h0040
// Increment step and 16-bit pointer mask
`define LSCB_INC 32'h0000_0001
`define LSCB_PTR16_MASK 32'h0000_FFFF
`define LSCB_ZERO32 32'h0000_0000
`endif

// ---- inc/lscb_pkg.sv ----
// Types for the status and counter block.
// Assumes no other package; constants live in lscb_defs.svh.
package lscb_pkg;
  // Command unit state codes
  typedef enum logic [2:0] {
    LSCB_CU_IDLE = 3'h0,
    LSCB_CU_SUSP = 3'h1,
    LSCB_CU_ACTV = 3'h2
  } lscb_cu_t;
  // Receive unit state codes
  typedef enum logic [3:0] {
    LSCB_RU_IDLE = 4'h0,
    LSCB_RU_SUSP = 4'h1,
    LSCB_RU_NORES = 4'h2,
    LSCB_RU_READY = 4'h4,
    LSCB_RU_NORES_RBD = 4'hA,
    LSCB_RU_NO_RBD = 4'hC
  } lscb_ru_t;
  // Memory sequencer states, one-hot
  typedef enum logic [6:0] {
    LSCB_S_IDLE = 7'h01,
    LSCB_S_STW = 7'h02,
    LSCB_S_CMDR = 7'h04,
    LSCB_S_PCL = 7'h08,
    LSCB_S_PRX = 7'h10,
    LSCB_S_CRD = 7'h20,
    LSCB_S_CWR = 7'h40
  } lscb_state_t;
endpackage : lscb_pkg

// ---- rtl/lscb_status_counters.sv ----
// Status word writer, pointer fetch and memory-resident error counters.
// Assumes a simple bus master port with one-cycle request/ack handshake to shared memory,
// and that the receive and command units report events as one-cycle pulses.
`include "lscb_defs.svh"

module lscb_status_counters (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  // Mode straps
  input wire logic compat_mode_i,
  input wire logic linear_mode_i,
  input wire logic monitor_mode_i,
  input wire logic [31:0] ctrl_base_i,
  // Unit events and states
  input wire logic cmd_done_irq_i,
  input wire logic frame_done_i,
  input wire logic [2:0] cu_state_i,
  input wire logic [3:0] ru_state_i,
  input wire logic throttle_loaded_i,
  // Channel attention
  input wire logic chan_attn_i,
  // Per-frame receive report
  input wire logic frame_end_i,
  input wire logic frame_good_i,
  input wire logic frame_crc_err_i,
  input wire logic frame_misaligned_i,
  input wire logic frame_short_i,
  input wire logic frame_no_res_i,
  input wire logic frame_overrun_i,
  input wire logic frame_collision_i,
  input wire logic frame_in_preamble_i,
  input wire logic [15:0] frame_bytes_i,
  // Memory master
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  output logic mem_lock_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // Results to the unit controllers
  output logic [15:0] status_word_o,
  output logic [31:0] cmd_list_ptr_o,
  output logic [31:0] rx_area_ptr_o,
  output logic cu_start_o,
  output logic ru_start_o,
  output logic cmd_word_cleared_o
);

  lscb_pkg::lscb_state_t state_r;
  logic cmd_done_flag_r;
  logic receive_done_flag_r;
  logic cmd_unit_inactive_flag_r;
  logic receive_unit_halted_flag_r;
  logic [2:0] cu_prev_r;
  logic [3:0] ru_prev_r;
  logic [`LSCB_NCNT-1:0] cnt_pend_r;
  logic [2:0] cnt_sel_r;
  logic [31:0] cnt_val_r;
  logic [31:0] cmd_word_r;
  logic attn_pend_r;
  logic status_dirty_r;
  logic [15:0] status_seen_r;
  logic overrun_prev_r;
  logic [31:0] cmd_list_ptr_r;
  logic [31:0] rx_area_ptr_r;
  logic cu_start_r;
  logic ru_start_r;
  logic cleared_r;
  logic [3:0] ack_take;
  logic [`LSCB_NCNT-1:0] cnt_new;
  logic [2:0] cnt_first;
  logic cnt_any;
  logic [2:0] cu_cmd;
  logic [2:0] ru_cmd;
  logic [2:0] cu_code;
  logic [3:0] ru_code;
  logic cu_left_active;
  logic ru_left_ready;
  logic sel_busy;
  logic idle_st;

  assign idle_st = (state_r == lscb_pkg::LSCB_S_IDLE);
  assign sel_busy = (state_r != lscb_pkg::LSCB_S_IDLE);

  // Command word fields as captured on channel attention
  assign cu_cmd = cmd_word_r[`LSCB_CU_CMD_HI+16:`LSCB_CU_CMD_LO+16];
  assign ru_cmd = cmd_word_r[`LSCB_RU_CMD_HI+16:`LSCB_RU_CMD_LO+16];
  // Acks apply only when the command read completes
  assign ack_take = (state_r == lscb_pkg::LSCB_S_CMDR && mem_ack_i) ?
                    {mem_rdata_i[`LSCB_ACK_CMD_DONE+16], mem_rdata_i[`LSCB_ACK_RX_DONE+16],
                     mem_rdata_i[`LSCB_ACK_CU_INACT+16], mem_rdata_i[`LSCB_ACK_RU_HALT+16]} :
                    4'h0;

  // Filter unused command unit codes to idle
  always_comb begin
    case (cu_state_i)
      lscb_pkg::LSCB_CU_SUSP: cu_code = lscb_pkg::LSCB_CU_SUSP;
      lscb_pkg::LSCB_CU_ACTV: cu_code = lscb_pkg::LSCB_CU_ACTV;
      default: cu_code = lscb_pkg::LSCB_CU_IDLE;
    endcase
  end

  // Legal receive codes only; extended ones hidden in compatibility
  always_comb begin
    case (ru_state_i)
      lscb_pkg::LSCB_RU_SUSP: ru_code = lscb_pkg::LSCB_RU_SUSP;
      lscb_pkg::LSCB_RU_NORES: ru_code = lscb_pkg::LSCB_RU_NORES;
      lscb_pkg::LSCB_RU_READY: ru_code = lscb_pkg::LSCB_RU_READY;
      lscb_pkg::LSCB_RU_NORES_RBD:
        ru_code = compat_mode_i ? lscb_pkg::LSCB_RU_NORES : lscb_pkg::LSCB_RU_NORES_RBD;
      lscb_pkg::LSCB_RU_NO_RBD:
        ru_code = compat_mode_i ? lscb_pkg::LSCB_RU_READY : lscb_pkg::LSCB_RU_NO_RBD;
      default: ru_code = lscb_pkg::LSCB_RU_IDLE;
    endcase
  end

  assign cu_left_active = (cu_prev_r == lscb_pkg::LSCB_CU_ACTV) &&
                          (cu_code != lscb_pkg::LSCB_CU_ACTV);
  assign ru_left_ready = (ru_prev_r == lscb_pkg::LSCB_RU_READY) &&
                         (ru_code != lscb_pkg::LSCB_RU_READY);

  // Unit state history for edge detection
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cu_prev_r <= lscb_pkg::LSCB_CU_IDLE;
      ru_prev_r <= lscb_pkg::LSCB_RU_IDLE;
    end else if (clk_en_i) begin
      cu_prev_r <= cu_code;
      ru_prev_r <= ru_code;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cmd_done_flag_r <= 1'b0;
      receive_done_flag_r <= 1'b0;
      cmd_unit_inactive_flag_r <= 1'b0;
      receive_unit_halted_flag_r <= 1'b0;
    end else if (clk_en_i) begin
      cmd_done_flag_r <= cmd_done_irq_i | (cmd_done_flag_r & ~ack_take[3]);
      receive_done_flag_r <= frame_done_i | (receive_done_flag_r & ~ack_take[2]);
      cmd_unit_inactive_flag_r <= cu_left_active | (cmd_unit_inactive_flag_r & ~ack_take[1]);
      receive_unit_halted_flag_r <= ru_left_ready | (receive_unit_halted_flag_r & ~ack_take[0]);
    end
  end

  // Status word assembly, throttle bit hidden in compatibility
  always_comb begin
    status_word_o = 16'h0000;
    status_word_o[`LSCB_BIT_CMD_DONE] = cmd_done_flag_r;
    status_word_o[`LSCB_BIT_RX_DONE] = receive_done_flag_r;
    status_word_o[`LSCB_BIT_CU_INACT] = cmd_unit_inactive_flag_r;
    status_word_o[`LSCB_BIT_RU_HALT] = receive_unit_halted_flag_r;
    status_word_o[`LSCB_CU_STATE_HI:`LSCB_CU_STATE_LO] = cu_code;
    status_word_o[`LSCB_RU_STATE_HI:`LSCB_RU_STATE_LO] = ru_code;
    status_word_o[`LSCB_BIT_THROT] = throttle_loaded_i & ~compat_mode_i;
  end

  // Status needs a memory write whenever any field changes; comparing the whole word
  // also catches the throttle bit and mode changes, which raise no event of their own
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      status_seen_r <= 16'h0000;
      status_dirty_r <= 1'b0;
    end else if (clk_en_i) begin
      status_seen_r <= status_word_o;
      if (status_word_o != status_seen_r) begin
        status_dirty_r <= 1'b1;
      end else if (state_r == lscb_pkg::LSCB_S_STW && mem_ack_i) begin
        status_dirty_r <= 1'b0;
      end
    end
  end

  // Channel attention latch; an attention during a pass is kept for later, except one that comes before the command read ack, which that ack clears
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      attn_pend_r <= 1'b0;
    end else if (clk_en_i) begin
      if (chan_attn_i) begin
        attn_pend_r <= 1'b1;
      end else if (state_r == lscb_pkg::LSCB_S_CMDR && mem_ack_i) begin
        attn_pend_r <= 1'b0;
      end
    end
  end

  // Which counters apply to a finished frame
  always_comb begin
    cnt_new = '0;
    if (frame_end_i && !frame_in_preamble_i) begin
      cnt_new[`LSCB_CNT_CRC] = frame_crc_err_i & ~frame_misaligned_i;
      cnt_new[`LSCB_CNT_ALN] = frame_crc_err_i & frame_misaligned_i;
      cnt_new[`LSCB_CNT_SHRT] = frame_short_i |
        (frame_collision_i && frame_bytes_i < `LSCB_MIN_CDT_BYTES);
      // Resource drops, or every frame in monitor mode
      cnt_new[`LSCB_CNT_RSC] = monitor_mode_i |
        (frame_good_i & frame_no_res_i & (ru_code == lscb_pkg::LSCB_RU_NORES ||
         ru_code == lscb_pkg::LSCB_RU_NORES_RBD));
      // First frame of an overrun episode only
      cnt_new[`LSCB_CNT_OVR] = frame_overrun_i & ~overrun_prev_r;
      cnt_new[`LSCB_CNT_CDT] = frame_collision_i && frame_bytes_i >= `LSCB_MIN_CDT_BYTES;
    end
  end

  // Overrun episode tracking over consecutive frames
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      overrun_prev_r <= 1'b0;
    end else if (clk_en_i && frame_end_i) begin
      overrun_prev_r <= frame_overrun_i;
    end
  end

  // Lowest pending counter is serviced first
  always_comb begin
    cnt_first = 3'h0;
    cnt_any = 1'b0;
    for (int i = `LSCB_NCNT - 1; i >= 0; i--) begin
      if (cnt_pend_r[i]) begin
        cnt_first = 3'(i);
        cnt_any = 1'b1;
      end
    end
  end

  // Pending set per counter; a new frame merges with work in flight
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnt_pend_r <= '0;
    end else if (clk_en_i) begin
      if (state_r == lscb_pkg::LSCB_S_CWR && mem_ack_i) begin
        cnt_pend_r <= (cnt_pend_r & ~(`LSCB_NCNT'(1) << cnt_sel_r)) | cnt_new;
      end else begin
        cnt_pend_r <= cnt_pend_r | cnt_new;
      end
    end
  end

  // Counter offset lookup
  function automatic logic [31:0] lscb_cnt_ofs(input logic [2:0] sel);
    case (sel)
      `LSCB_CNT_CRC: lscb_cnt_ofs = `LSCB_OFS_CRC;
      `LSCB_CNT_ALN: lscb_cnt_ofs = `LSCB_OFS_ALN;
      `LSCB_CNT_SHRT: lscb_cnt_ofs = `LSCB_OFS_SHRT;
      `LSCB_CNT_RSC: lscb_cnt_ofs = `LSCB_OFS_RSC;
      `LSCB_CNT_OVR: lscb_cnt_ofs = `LSCB_OFS_OVR;
      default: lscb_cnt_ofs = `LSCB_OFS_CDT;
    endcase
  endfunction : lscb_cnt_ofs

  // Memory sequencer; attention first, then counters, then status write-back
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_r <= lscb_pkg::LSCB_S_IDLE;
      cnt_sel_r <= 3'h0;
    end else if (clk_en_i) begin
      case (state_r)
        lscb_pkg::LSCB_S_IDLE: begin
          if (attn_pend_r) begin
            state_r <= lscb_pkg::LSCB_S_CMDR;
          end else if (cnt_any) begin
            cnt_sel_r <= cnt_first;
            state_r <= lscb_pkg::LSCB_S_CRD;
          end else if (status_dirty_r) begin
            state_r <= lscb_pkg::LSCB_S_STW;
          end
        end
        lscb_pkg::LSCB_S_CMDR: begin
          if (mem_ack_i) begin
            state_r <= lscb_pkg::LSCB_S_STW;
          end
        end
        lscb_pkg::LSCB_S_STW: begin
          if (mem_ack_i) begin
            if (cu_cmd == `LSCB_CMD_START) begin
              state_r <= lscb_pkg::LSCB_S_PCL;
            end else if (ru_cmd == `LSCB_CMD_START) begin
              state_r <= lscb_pkg::LSCB_S_PRX;
            end else begin
              state_r <= lscb_pkg::LSCB_S_IDLE;
            end
          end
        end
        lscb_pkg::LSCB_S_PCL: begin
          if (mem_ack_i) begin
            state_r <= (ru_cmd == `LSCB_CMD_START) ? lscb_pkg::LSCB_S_PRX : lscb_pkg::LSCB_S_IDLE;
          end
        end
        lscb_pkg::LSCB_S_PRX: begin
          if (mem_ack_i) begin
            state_r <= lscb_pkg::LSCB_S_IDLE;
          end
        end
        // Read then write back under lock
        lscb_pkg::LSCB_S_CRD: begin
          if (mem_ack_i) begin
            state_r <= lscb_pkg::LSCB_S_CWR;
          end
        end
        lscb_pkg::LSCB_S_CWR: begin
          if (mem_ack_i) begin
            state_r <= lscb_pkg::LSCB_S_IDLE;
          end
        end
        default: state_r <= lscb_pkg::LSCB_S_IDLE;
      endcase
    end
  end

  // Captured value plus one, wrapping at 32 bits
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnt_val_r <= `LSCB_ZERO32;
    end else if (clk_en_i && state_r == lscb_pkg::LSCB_S_CRD && mem_ack_i) begin
      cnt_val_r <= mem_rdata_i + `LSCB_INC;
    end
  end

  // Command word capture; status write-back clears it in memory
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cmd_word_r <= `LSCB_ZERO32;
    end else if (clk_en_i) begin
      if (state_r == lscb_pkg::LSCB_S_CMDR && mem_ack_i) begin
        cmd_word_r <= mem_rdata_i;
      end else if (idle_st) begin
        cmd_word_r <= `LSCB_ZERO32;
      end
    end
  end

  // Pointer capture, masked to 16 bits unless linear mode
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cmd_list_ptr_r <= `LSCB_ZERO32;
      rx_area_ptr_r <= `LSCB_ZERO32;
      cu_start_r <= 1'b0;
      ru_start_r <= 1'b0;
      cleared_r <= 1'b0;
    end else if (clk_en_i) begin
      cu_start_r <= 1'b0;
      ru_start_r <= 1'b0;
      // Pulse once a captured first long word, nonzero in either half, is written back with its command half zero
      cleared_r <= (state_r == lscb_pkg::LSCB_S_STW) && mem_ack_i && (cmd_word_r != `LSCB_ZERO32);
      if (state_r == lscb_pkg::LSCB_S_PCL && mem_ack_i) begin
        cmd_list_ptr_r <= linear_mode_i ? mem_rdata_i : (mem_rdata_i & `LSCB_PTR16_MASK);
        cu_start_r <= 1'b1;
      end
      if (state_r == lscb_pkg::LSCB_S_PRX && mem_ack_i) begin
        rx_area_ptr_r <= linear_mode_i ? mem_rdata_i : (mem_rdata_i & `LSCB_PTR16_MASK);
        ru_start_r <= 1'b1;
      end
    end
  end

  // Bus request decode; request holds until acknowledged
  always_comb begin
    mem_req_o = sel_busy;
    mem_we_o = 1'b0;
    mem_addr_o = ctrl_base_i;
    mem_wdata_o = `LSCB_ZERO32;
    // Lock spans both halves of the counter update
    mem_lock_o = (state_r == lscb_pkg::LSCB_S_CRD) || (state_r == lscb_pkg::LSCB_S_CWR);
    case (state_r)
      lscb_pkg::LSCB_S_STW: begin
        // Status low half, command half written as zero
        mem_we_o = 1'b1;
        mem_addr_o = ctrl_base_i + `LSCB_OFS_STATUS;
        mem_wdata_o = {16'h0000, status_word_o};
      end
      lscb_pkg::LSCB_S_CMDR: mem_addr_o = ctrl_base_i + `LSCB_OFS_STATUS;
      lscb_pkg::LSCB_S_PCL: mem_addr_o = ctrl_base_i + `LSCB_OFS_CMDLIST;
      lscb_pkg::LSCB_S_PRX: mem_addr_o = ctrl_base_i + `LSCB_OFS_RXAREA;
      lscb_pkg::LSCB_S_CRD: mem_addr_o = ctrl_base_i + lscb_cnt_ofs(cnt_sel_r);
      lscb_pkg::LSCB_S_CWR: begin
        mem_we_o = 1'b1;
        mem_addr_o = ctrl_base_i + lscb_cnt_ofs(cnt_sel_r);
        mem_wdata_o = cnt_val_r;
      end
      default: mem_req_o = 1'b0;
    endcase
  end

  assign cmd_list_ptr_o = cmd_list_ptr_r;
  assign rx_area_ptr_o = rx_area_ptr_r;
  assign cu_start_o = cu_start_r;
  assign ru_start_o = ru_start_r;
  assign cmd_word_cleared_o = cleared_r;

endmodule : lscb_status_counters

// ---- test/lscb_checker.sv ----
// Port assertions for the status and counter block.
// Assumes one clock, a synchronous active-low reset and clk_en_i held high.
module lscb_checker (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Watched ports
  input wire logic compat_mode_i,
  input wire logic linear_mode_i,
  input wire logic cmd_done_irq_i,
  input wire logic frame_done_i,
  input wire logic [2:0] cu_state_i,
  input wire logic [3:0] ru_state_i,
  input wire logic throttle_loaded_i,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic mem_lock_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic [15:0] status_word_o,
  input wire logic [31:0] cmd_list_ptr_o,
  input wire logic cu_start_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Locked counter pair, bus hold, status field and short pointer checks
  a_incr_write_back: assert property (
    (mem_req_o && mem_ack_i && mem_lock_o && !mem_we_o) |=> mem_req_o && mem_we_o && mem_lock_o
    && mem_addr_o == $past(mem_addr_o) && mem_wdata_o == $past(mem_rdata_i) + 32'h0000_0001)
    else $error("counter write-back is not read value plus one");
  a_lock_until_write: assert property ($fell(mem_lock_o) |-> $past(mem_we_o && mem_ack_i))
    else $error("lock dropped before the write was acknowledged");
  a_request_stands: assert property ((mem_req_o && !mem_ack_i) |=> mem_req_o
    && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_lock_o))
    else $error("bus request changed before acknowledge");
  a_cmd_done_set: assert property (cmd_done_irq_i |=> status_word_o[15])
    else $error("command done flag not set");
  a_rx_done_set: assert property (frame_done_i |=> status_word_o[14])
    else $error("receive done flag not set");
  a_cu_left_active: assert property (
    ($past(cu_state_i) == 3'h2 && cu_state_i != 3'h2) |-> ##[0:2] status_word_o[13])
    else $error("command unit inactive flag not set");
  a_ru_left_ready: assert property (
    ($past(ru_state_i) == 4'h4 && ru_state_i != 4'h4) |-> ##[0:2] status_word_o[12])
    else $error("receive unit halted flag not set");
  a_cus_field: assert property (
    status_word_o[11:8] == {1'b0, (cu_state_i > 3'h2) ? 3'h0 : cu_state_i})
    else $error("command unit state field wrong");
  a_compat_codes: assert property (compat_mode_i |-> !status_word_o[3]
    && status_word_o[7:4] inside {4'h0, 4'h1, 4'h2, 4'h4})
    else $error("compatibility status shows extended code");
  a_throttle_bit: assert property (!compat_mode_i |-> status_word_o[3] == throttle_loaded_i
    && status_word_o[7:4] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'hA, 4'hC})
    else $error("throttle bit or receive state code wrong");
  a_short_pointer: assert property ((cu_start_o && !linear_mode_i)
    |-> cmd_list_ptr_o[31:16] == 16'h0000)
    else $error("short command pointer has upper bits");
  // Main scenarios
  c_counter_write: cover property (mem_req_o && mem_ack_i && mem_lock_o && mem_we_o);
  c_cu_start: cover property (cu_start_o);
  c_compat_ext: cover property (compat_mode_i && ru_state_i == 4'hA);
endmodule : lscb_checker

bind lscb_status_counters lscb_checker i_chk (.ref_clk_i, .nrst_i, .compat_mode_i,
  .linear_mode_i, .cmd_done_irq_i, .frame_done_i, .cu_state_i, .ru_state_i, .throttle_loaded_i,
  .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_lock_o, .mem_ack_i, .mem_rdata_i,
  .status_word_o, .cmd_list_ptr_o, .cu_start_o);

// ---- test/lscb_mem_model.sv ----
// Shared memory model holding the control block words and counters.
// Assumes word index from address bits 5:2 and the block's req/ack master.
module lscb_mem_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Wait cycles before each ack
  input wire logic [1:0] lat_i,
  // Master side
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:15];
  logic [1:0] wait_r;
  // Plain always so the host side may also poke words while the bus is idle
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ack_o <= 1'b0;
      wait_r <= 2'h0;
      rdata_o <= 32'h0000_0000;
    end else if (ack_o || !req_i) begin
      ack_o <= 1'b0;
      wait_r <= 2'h0;
      rdata_o <= ~rdata_o; // Stale data toggles so nothing relies on it
    end else if (wait_r == lat_i) begin
      ack_o <= 1'b1;
      rdata_o <= mem[addr_i[5:2]];
      if (we_i) begin
        mem[addr_i[5:2]] <= wdata_i;
      end
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule : lscb_mem_model

// ---- test/tb_top.sv ----
// Self-checking bench for status word, pointer fetch and memory counters.
// Assumes the memory model answers the master port; base address fixed.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i, nrst_i, compat_mode_i, linear_mode_i, monitor_mode_i, cmd_done_irq_i;
  logic frame_done_i, throttle_loaded_i, chan_attn_i, frame_end_i, mem_ack_i;
  logic mem_req_o, mem_we_o, mem_lock_o, cu_start_o, ru_start_o, cmd_word_cleared_o;
  logic [2:0] cu_state_i;
  logic [3:0] ru_state_i;
  logic [7:0] q;
  logic [15:0] frame_bytes_i, status_word_o;
  logic [1:0] lat;
  logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i, cmd_list_ptr_o, rx_area_ptr_o;
  logic [31:0] exp_cnt [6];
  int fail_count = 0;
  int tests_run = 0;
  int n_cu = 0, n_ru = 0, n_clr = 0;
  // Start and clear pulses last one cycle, so one falling-edge sample counts each once
  always @(negedge ref_clk_i) begin
    n_cu += cu_start_o;
    n_ru += ru_start_o;
    n_clr += cmd_word_cleared_o;
  end
  localparam int WIDX [6] = '{3, 4, 8, 5, 6, 7}; // CRC ALN SHRT RSC OVR CDT words
  lscb_status_counters i_dut (.ref_clk_i, .nrst_i, .clk_en_i(1'b1), .compat_mode_i,
    .linear_mode_i, .monitor_mode_i, .ctrl_base_i(32'h0000_0100), .cmd_done_irq_i,
    .frame_done_i, .cu_state_i, .ru_state_i, .throttle_loaded_i, .chan_attn_i, .frame_end_i,
    .frame_good_i(q[7]), .frame_crc_err_i(q[6]), .frame_misaligned_i(q[5]),
    .frame_short_i(q[4]), .frame_no_res_i(q[3]), .frame_overrun_i(q[2]),
    .frame_collision_i(q[1]), .frame_in_preamble_i(q[0]), .frame_bytes_i, .mem_req_o,
    .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_lock_o, .mem_ack_i, .mem_rdata_i,
    .status_word_o, .cmd_list_ptr_o, .rx_area_ptr_o, .cu_start_o, .ru_start_o,
    .cmd_word_cleared_o);
  lscb_mem_model i_mem (.ref_clk_i, .nrst_i, .lat_i(lat), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  // Single exit point for the run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk
  // Bounded wait for a quiet bus; a hang ends the run
  task automatic wait_idle();
    int quiet = 0;
    for (int n = 0; n < 400 && quiet < 6; n++) begin
      @(negedge ref_clk_i);
      quiet = mem_req_o ? 0 : quiet + 1;
    end
    if (quiet < 6) begin
      fail_count++;
      $display("unexpected bus state expected idle seen busy");
      print_verdict();
    end
  endtask : wait_idle
  task automatic pulse(input logic [2:0] sel);
    @(negedge ref_clk_i);
    {cmd_done_irq_i, frame_done_i, chan_attn_i} = sel;
    @(negedge ref_clk_i);
    {cmd_done_irq_i, frame_done_i, chan_attn_i} = 3'h0;
    wait_idle();
  endtask : pulse
  // Flags, state fields, acknowledge and compatibility codes
  task automatic t_flags();
    chk("flags after reset", 32'h0, {16'h0, status_word_o[15:12], cmd_list_ptr_o[11:0]});
    cu_state_i = 3'h2;
    ru_state_i = 4'h4;
    throttle_loaded_i = 1'b1;
    pulse(3'h6);
    cu_state_i = 3'h0;
    ru_state_i = 4'h2;
    wait_idle();
    chk("status", 32'h0000_F028, {16'h0, status_word_o});
    chk("stored status", 32'h0000_F028, i_mem.mem[0]);
    i_mem.mem[0] = 32'hA000_F028;
    pulse(3'h1);
    chk("acked status", 32'h0000_5028, {16'h0, status_word_o});
    chk("command word", 32'h0, {16'h0, i_mem.mem[0][31:16]});
    {compat_mode_i, cu_state_i, ru_state_i} = {1'b1, 3'h5, 4'hA};
    @(negedge ref_clk_i);
    chk("compat status", 32'h0000_5020, {16'h0, status_word_o});
    {compat_mode_i, cu_state_i, ru_state_i} = {1'b0, 3'h0, 4'hC};
    @(negedge ref_clk_i);
    chk("extended status", 32'h0000_50C8, {16'h0, status_word_o});
    ru_state_i = 4'h0;
    wait_idle();
    throttle_loaded_i = 1'b0;
    wait_idle();
    chk("stored throttle", 32'h0000_5000, i_mem.mem[0]);
  endtask : t_flags
  // Pointer fetch only on start, width by mode, prompt memory
  task automatic t_start();
    lat = 2'h0;
    i_mem.mem[1] = 32'h1234_5678;
    i_mem.mem[2] = 32'hABCD_0042;
    i_mem.mem[0] = 32'h0110_0000;
    pulse(3'h1);
    chk("short command pointer", 32'h0000_5678, cmd_list_ptr_o);
    chk("short receive pointer", 32'h0000_0042, rx_area_ptr_o);
    linear_mode_i = 1'b1;
    i_mem.mem[2] = 32'h0000_0099;
    i_mem.mem[0] = 32'h0120_0000;
    pulse(3'h1);
    chk("long command pointer", 32'h1234_5678, cmd_list_ptr_o);
    chk("receive pointer kept", 32'h0000_0042, rx_area_ptr_o);
    chk("start pulses", 32'h0000_0213, 32'(n_cu * 256 + n_ru * 16 + n_clr));
  endtask : t_start
  // One frame report, then every counter against its expected value
  task automatic fr(input logic [7:0] qual, input logic [15:0] nb, input logic [3:0] receive_unit_state,
                    input logic mon, input logic [5:0] inc);
    @(negedge ref_clk_i);
    {q, frame_bytes_i, ru_state_i, monitor_mode_i, frame_end_i} = {qual, nb, receive_unit_state, mon, 1'b1};
    @(negedge ref_clk_i);
    frame_end_i = 1'b0;
    wait_idle();
    for (int k = 0; k < 6; k++) begin
      exp_cnt[k] = exp_cnt[k] + inc[k];
      chk($sformatf("counter %0d", k), exp_cnt[k], i_mem.mem[WIDX[k]]);
    end
  endtask : fr
  // Counters with slow memory: each kind, wrap, overrun episode, collisions
  task automatic t_frames();
    lat = 2'h3;
    for (int k = 0; k < 6; k++) begin
      exp_cnt[k] = 32'h0;
    end
    exp_cnt[0] = 32'hFFFF_FFFF;
    i_mem.mem[3] = 32'hFFFF_FFFF;
    fr(8'h40, 16'h0080, 4'h0, 1'b0, 6'h01);
    fr(8'h60, 16'h0080, 4'h1, 1'b0, 6'h02);
    fr(8'h10, 16'h0020, 4'h4, 1'b0, 6'h04);
    fr(8'h88, 16'h0080, 4'h2, 1'b0, 6'h08);
    fr(8'h88, 16'h0080, 4'h4, 1'b0, 6'h00);
    fr(8'h80, 16'h0080, 4'h4, 1'b1, 6'h08);
    fr(8'h04, 16'h0080, 4'h4, 1'b0, 6'h10);
    fr(8'h04, 16'h0080, 4'h4, 1'b0, 6'h00);
    fr(8'h80, 16'h0080, 4'h4, 1'b0, 6'h00);
    fr(8'h04, 16'h0080, 4'h4, 1'b0, 6'h10);
    fr(8'h02, 16'h0040, 4'h4, 1'b0, 6'h20);
    fr(8'h02, 16'h003F, 4'h4, 1'b0, 6'h04);
    fr(8'h03, 16'h0000, 4'h4, 1'b0, 6'h00);
    fr(8'h52, 16'h0064, 4'h4, 1'b0, 6'h25);
  endtask : t_frames
  // Free-running clock at 50 ns
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // Main sequence
  initial begin
    nrst_i = 1'b0;
    {compat_mode_i, linear_mode_i, monitor_mode_i, cmd_done_irq_i, frame_done_i} = 5'h00;
    {throttle_loaded_i, chan_attn_i, frame_end_i, cu_state_i, ru_state_i} = 10'h000;
    {q, frame_bytes_i, lat} = 26'h0;
    for (int i = 0; i < 16; i++) begin
      i_mem.mem[i] = 32'h0;
    end
    repeat (20) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    t_flags();
    t_start();
    // host writes only while bus idle
    t_frames();
    print_verdict();
  end
endmodule : tb_top
